// ==== fom_cfg.svh ====
`ifndef FOM_CFG_SVH
`define FOM_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define FOM_ADDR_SEL_A_LOW   8'h15
`define FOM_ADDR_TYPE_A      8'h16
`define FOM_ADDR_SEL_B_LOW   8'h17
`define FOM_ADDR_TYPE_B      8'h18

// ****************************************************************
// field positions in the type/polarity registers
// ****************************************************************
`define FOM_HI_SEL_MSB       3
`define FOM_BIT_OV           4
`define FOM_BIT_UV           5
`define FOM_BIT_EW           6
`define FOM_BIT_POL          7

// ****************************************************************
// reset values
// ****************************************************************
`define FOM_RST_REG          8'h00

// ****************************************************************
// general pin mode codes
// ****************************************************************
`define FOM_MODE_PP_FAULT    3'h3
`define FOM_MODE_OD_FAULT    3'h4
`define FOM_MODE_SPECIAL     3'h7

`endif

// ==== fom_pkg.sv ====
package fom_pkg;

	// comparator flags of one monitored input
	typedef struct packed {
		logic ov;
		logic uv;
		logic ew;
	} fom_flags_t;

	// one open-drain or push-pull pin
	typedef struct packed {
		logic o;
		logic oe;
	} fom_pin_t;

	// margin pin decode
	typedef enum logic [1:0] {
		FOM_BANK_NORMAL,
		FOM_BANK_RAISE,
		FOM_BANK_LOWER
	} fom_bank_t;

endpackage

// ==== fom_fault_sel.sv ====
`include "fom_cfg.svh"

// one dedicated fault output combiner
module fom_fault_sel #(
	parameter int N = 12
) (
	// configuration
	input  wire logic [7:0]                sel_low,
	input  wire logic [7:0]                type_pol,
	input  wire logic                      hi_ok,
	// flags
	input  wire logic [N-1:0]              ov,
	input  wire logic [N-1:0]              uv,
	input  wire logic [N-1:0]              ew,
	// result, active high
	output logic                           fault
);
	logic [11:0] sel;
	logic [11:0] hit;

	// inputs above eight only count on the twelve-channel variant
	always_comb begin
		sel        = '0;
		sel[7:0]   = sel_low;
		sel[11:8]  = hi_ok ? type_pol[`FOM_HI_SEL_MSB:0] : 4'h0; // see R16
		hit        = '0;
		for (int i = 0; i < N && i < 12; i++) begin
			hit[i] = (ov[i] & type_pol[`FOM_BIT_OV])
			       | (uv[i] & type_pol[`FOM_BIT_UV])
			       | (ew[i] & type_pol[`FOM_BIT_EW]); // see R4 see R7
		end
		fault = |(hit & sel); // see R3 see R6 see R9
	end
endmodule

// ==== fom_top.sv ====
// Notes on behaviour
// R1: global fault on any input violation
// R2: fault A on pin five, B on six
// R3: fault A selects inputs by two registers
// R4: fault A enables over, under, warning causes
// R5: fault A polarity from bit seven
// R6: fault B selects inputs by two registers
// R7: fault B enables over, under, warning causes
// R8: fault B polarity from bit seven
// R9: each fault ORs selected enabled violations
// R10: sequencing fault drops enables, saves data
// R11: pins two, three are margin raise, lower
// R12: margin pins choose trim code bank
// R13: one pin low closes trim switches
// R14: either margin pin enables margin function
// R15: margin holds fault outputs, blocks logging
// R16: eight channel variant ignores inputs nine-twelve
`include "fom_cfg.svh"

module fom_top #(
	parameter int   N_MON      = 12,
	parameter int   N_DAC      = 12
) (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      nrst,
	// register port
	input  wire logic [7:0]                reg_addr,
	input  wire logic [7:0]                reg_wdata,
	input  wire logic                      reg_wr,
	output logic      [7:0]                reg_rdata,
	// comparator flags, one set per monitored input
	input  wire fom_pkg::fom_flags_t [N_MON-1:0] monitored_input,
	// general pin modes and margin switch from outside this block
	input  wire logic [2:0]                pin_mode [6],
	input  wire logic                      margin_in_n,
	input  wire logic                      margin_reg_en,
	// sequencing state
	input  wire logic                      seq_active,
	input  wire logic                      seq_fault,
	// pins
	input  wire logic                      general_pin_two,
	input  wire logic                      general_pin_three,
	output fom_pkg::fom_pin_t              general_pin_one,
	output fom_pkg::fom_pin_t              general_pin_four,
	output fom_pkg::fom_pin_t              general_pin_five,
	output fom_pkg::fom_pin_t              general_pin_six,
	output fom_pkg::fom_pin_t              any_fault_pin_two,
	output fom_pkg::fom_pin_t              any_fault_pin_three,
	// status
	output logic                           fault_out_a,
	output logic                           fault_out_b,
	output logic                           any_fault,
	output logic                           sequencing_fault_out,
	output logic                           margin_active,
	output logic                           log_trigger,
	output logic                           enables_off,
	// trim dac control
	output fom_pkg::fom_bank_t             trim_dac_bank,
	output logic                           trim_dac_out_close,
	input  wire logic [N_DAC-1:0]          dac_switch_cfg,
	output logic      [N_DAC-1:0]          trim_dac_out_sw
);
	import fom_pkg::*;

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic [2:0] sync1_q, sync1_d;
	logic [2:0] sync2_q, sync2_d;
	logic       raise_n, lower_n, marg_n;

	// two flops per asynchronous pin
	always_comb begin
		sync1_d = {margin_in_n, general_pin_three, general_pin_two};
		sync2_d = sync1_q;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1_q <= 3'h7;
			sync2_q <= 3'h7;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
		end
	end

	assign raise_n = sync2_q[0];
	assign lower_n = sync2_q[1];
	assign marg_n  = sync2_q[2];

	// ****************************************************************
	// configuration registers
	// ****************************************************************
	logic [7:0] sel_a_q, sel_a_d;
	logic [7:0] typ_a_q, typ_a_d;
	logic [7:0] sel_b_q, sel_b_d;
	logic [7:0] typ_b_q, typ_b_d;
	logic [7:0] rdata_q, rdata_d;

	// write decode
	always_comb begin
		sel_a_d = sel_a_q;
		typ_a_d = typ_a_q;
		sel_b_d = sel_b_q;
		typ_b_d = typ_b_q;
		if (reg_wr) begin
			if (reg_addr == `FOM_ADDR_SEL_A_LOW) begin
				sel_a_d = reg_wdata;
			end else if (reg_addr == `FOM_ADDR_TYPE_A) begin
				typ_a_d = reg_wdata;
			end else if (reg_addr == `FOM_ADDR_SEL_B_LOW) begin
				sel_b_d = reg_wdata;
			end else if (reg_addr == `FOM_ADDR_TYPE_B) begin
				typ_b_d = reg_wdata;
			end
		end
	end

	// read decode, unmapped reads as zero
	always_comb begin
		if (reg_addr == `FOM_ADDR_SEL_A_LOW) begin
			rdata_d = sel_a_q;
		end else if (reg_addr == `FOM_ADDR_TYPE_A) begin
			rdata_d = typ_a_q;
		end else if (reg_addr == `FOM_ADDR_SEL_B_LOW) begin
			rdata_d = sel_b_q;
		end else if (reg_addr == `FOM_ADDR_TYPE_B) begin
			rdata_d = typ_b_q;
		end else begin
			rdata_d = 8'h00;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sel_a_q <= `FOM_RST_REG;
			typ_a_q <= `FOM_RST_REG;
			sel_b_q <= `FOM_RST_REG;
			typ_b_q <= `FOM_RST_REG;
			rdata_q <= 8'h00;
		end else begin
			sel_a_q <= sel_a_d;
			typ_a_q <= typ_a_d;
			sel_b_q <= sel_b_d;
			typ_b_q <= typ_b_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// ****************************************************************
	// fault combination
	// ****************************************************************
	logic [N_MON-1:0] ov, uv, ew;
	logic             raw_a, raw_b, raw_any;
	logic             hi_ok;
	logic             raise_mode, lower_mode;

	// flatten comparator flags
	always_comb begin
		for (int i = 0; i < N_MON; i++) begin
			ov[i] = monitored_input[i].ov;
			uv[i] = monitored_input[i].uv;
			ew[i] = monitored_input[i].ew;
		end
	end

	assign hi_ok   = (N_MON > 8); // see R16
	assign raw_any = |(ov | uv | ew); // see R1

	fom_fault_sel #(.N(N_MON)) u_sel_a (
		.sel_low  (sel_a_q),
		.type_pol (typ_a_q),
		.hi_ok    (hi_ok),
		.ov       (ov),
		.uv       (uv),
		.ew       (ew),
		.fault    (raw_a)
	);

	fom_fault_sel #(.N(N_MON)) u_sel_b (
		.sel_low  (sel_b_q),
		.type_pol (typ_b_q),
		.hi_ok    (hi_ok),
		.ov       (ov),
		.uv       (uv),
		.ew       (ew),
		.fault    (raw_b)
	);

	// ****************************************************************
	// margin decode
	// ****************************************************************
	logic      marg_on;
	fom_bank_t bank;
	logic      one_low;

	// margin pins act only in their margin modes
	always_comb begin
		raise_mode = (pin_mode[1] == `FOM_MODE_SPECIAL); // see R11
		lower_mode = (pin_mode[2] == `FOM_MODE_SPECIAL); // see R11
		one_low    = raise_mode && lower_mode && (raise_n != lower_n);
		if (one_low && !raise_n) begin
			bank = FOM_BANK_RAISE; // see R12
		end else if (one_low && !lower_n) begin
			bank = FOM_BANK_LOWER; // see R12
		end else begin
			bank = FOM_BANK_NORMAL; // see R12
		end
		marg_on = one_low || margin_reg_en || (pin_mode[5] == 3'h0 && !marg_n); // see R14
	end

	// ****************************************************************
	// held fault state and outputs
	// ****************************************************************
	logic             fa_q, fa_d, fb_q, fb_d, fany_q, fany_d;
	logic             seqf_q, seqf_d, log_q, log_d, enoff_q, enoff_d;
	logic             marg_q, close_q, close_d;
	fom_bank_t        bank_q;
	logic [N_DAC-1:0] sw_q, sw_d;
	fom_pin_t         p1_d, p4_d, p5_d, p6_d, p2_d, p3_d;
	fom_pin_t         p1_q, p4_q, p5_q, p6_q, p2_q, p3_q;

	// margin freezes the a, b and any fault states, clears the sequencing fault and blocks logging
	always_comb begin
		fa_d    = marg_on ? fa_q   : raw_a;   // see R15
		fb_d    = marg_on ? fb_q   : raw_b;   // see R15
		fany_d  = marg_on ? fany_q : raw_any; // see R15
		seqf_d  = (pin_mode[5] == `FOM_MODE_SPECIAL) && seq_active && seq_fault
		          && !marg_on; // see R10
		log_d   = seqf_d && !seqf_q && !marg_on; // see R10 see R15
		enoff_d = seqf_d; // see R10
		close_d = one_low; // see R13
		sw_d    = one_low ? {N_DAC{1'b1}} : dac_switch_cfg; // see R13
	end

	// pin drive from mode codes
	function automatic fom_pin_t drive(input logic [2:0] mode, input logic act_high,
	                                    input logic active);
		fom_pin_t p;
		logic     lvl;
		lvl  = act_high ? active : !active;
		p.o  = lvl;
		p.oe = 1'b0;
		if (mode == `FOM_MODE_PP_FAULT) begin
			p.oe = 1'b1;
		end else if (mode == `FOM_MODE_OD_FAULT) begin
			p.o  = 1'b0;
			p.oe = !lvl;
		end
		return p;
	endfunction

	// pin assignment per general pin
	always_comb begin
		p1_d = drive(pin_mode[0], 1'b0, fany_d); // see R1
		p2_d = drive(pin_mode[1], 1'b0, fany_d); // see R1
		p3_d = drive(pin_mode[2], 1'b0, fany_d); // see R1
		p4_d = drive(pin_mode[3], 1'b0, fany_d); // see R1
		p5_d = drive(pin_mode[4], typ_a_q[`FOM_BIT_POL], fa_d); // see R2 see R5
		p6_d = drive(pin_mode[5], typ_b_q[`FOM_BIT_POL], fb_d); // see R2 see R8
		if (pin_mode[5] == `FOM_MODE_SPECIAL) begin
			p6_d.o  = 1'b0;
			p6_d.oe = seqf_d; // see R10
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fa_q    <= 1'b0;
			fb_q    <= 1'b0;
			fany_q  <= 1'b0;
			seqf_q  <= 1'b0;
			log_q   <= 1'b0;
			enoff_q <= 1'b0;
			marg_q  <= 1'b0;
			close_q <= 1'b0;
			bank_q  <= FOM_BANK_NORMAL;
			sw_q    <= '0;
			p1_q    <= '0;
			p2_q    <= '0;
			p3_q    <= '0;
			p4_q    <= '0;
			p5_q    <= '0;
			p6_q    <= '0;
		end else begin
			fa_q    <= fa_d;
			fb_q    <= fb_d;
			fany_q  <= fany_d;
			seqf_q  <= seqf_d;
			log_q   <= log_d;
			enoff_q <= enoff_d;
			marg_q  <= marg_on;
			close_q <= close_d;
			bank_q  <= bank;
			sw_q    <= sw_d;
			p1_q    <= p1_d;
			p2_q    <= p2_d;
			p3_q    <= p3_d;
			p4_q    <= p4_d;
			p5_q    <= p5_d;
			p6_q    <= p6_d;
		end
	end

	// registered outputs
	assign fault_out_a          = fa_q;
	assign fault_out_b          = fb_q;
	assign any_fault            = fany_q;
	assign sequencing_fault_out = seqf_q;
	assign log_trigger          = log_q;
	assign enables_off          = enoff_q;
	assign margin_active        = marg_q;
	assign trim_dac_bank        = bank_q;
	assign trim_dac_out_close   = close_q;
	assign trim_dac_out_sw      = sw_q;
	assign general_pin_one      = p1_q;
	assign any_fault_pin_two    = p2_q;
	assign any_fault_pin_three  = p3_q;
	assign general_pin_four     = p4_q;
	assign general_pin_five     = p5_q;
	assign general_pin_six      = p6_q;
endmodule

// ==== fom_top_props.sv ====
// ****************
// fault routing checks
// ****************
module fom_top_props #(
	parameter int N_MON = 12,
	parameter int N_DAC = 12
) (
	// clock and reset
	input wire logic				clk,
	input wire logic				nrst,
	// inputs watched
	input wire fom_pkg::fom_flags_t [N_MON-1:0]	monitored_input,
	input wire logic [2:0]				pin_mode [6],
	input wire logic				general_pin_two,
	input wire logic				general_pin_three,
	// outputs watched
	input wire logic				fault_out_a,
	input wire logic				fault_out_b,
	input wire logic				any_fault,
	input wire logic				sequencing_fault_out,
	input wire logic				margin_active,
	input wire logic				log_trigger,
	input wire logic				enables_off,
	input wire fom_pkg::fom_bank_t			trim_dac_bank,
	input wire logic				trim_dac_out_close,
	input wire logic [N_DAC-1:0]			trim_dac_out_sw
);
	import fom_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// both margin pins set to margin mode
	logic m_ok;
	assign m_ok = pin_mode[1] == 3'h7 && pin_mode[2] == 3'h7;
	// one margin pin held low past the sync and register stages
	sequence s_raise;
		(m_ok && !general_pin_two && general_pin_three) [*4];
	endsequence
	sequence s_lower;
		(m_ok && general_pin_two && !general_pin_three) [*4];
	endsequence
	sequence s_frozen;
		margin_active [*2];
	endsequence
	property p_raise;
		s_raise |-> trim_dac_bank == FOM_BANK_RAISE && trim_dac_out_close;
	endproperty
	a_raise: assert property (p_raise) else $error("raise bank wrong");
	property p_lower;
		s_lower |-> trim_dac_bank == FOM_BANK_LOWER && trim_dac_out_close;
	endproperty
	a_lower: assert property (p_lower) else $error("lower bank wrong");
	property p_sw;
		trim_dac_out_close |-> &trim_dac_out_sw;
	endproperty
	a_sw: assert property (p_sw) else $error("switches open");
	property p_margin;
		trim_dac_out_close |-> margin_active;
	endproperty
	a_margin: assert property (p_margin) else $error("margin off");
	property p_frozen;
		s_frozen |-> $stable(fault_out_a) && $stable(fault_out_b) && $stable(any_fault);
	endproperty
	a_frozen: assert property (p_frozen) else $error("fault moved");
	property p_any;
		$past(nrst) && !margin_active && !$past(margin_active)
			|-> any_fault == |$past(monitored_input);
	endproperty
	a_any: assert property (p_any) else $error("any fault wrong");
	property p_log;
		log_trigger |=> !log_trigger;
	endproperty
	a_log: assert property (p_log) else $error("log too long");
	property p_seq;
		sequencing_fault_out |-> enables_off;
	endproperty
	a_seq: assert property (p_seq) else $error("enables on");
endmodule

// ==== fom_ctrl_model.sv ====
// ****************
// system controller on the pins
// ****************
module fom_ctrl_model (
	// margin request, raise then lower, low active
	input wire logic [1:0]		drive_n,
	// fault pins watched
	input wire fom_pkg::fom_pin_t	pin_five,
	input wire fom_pkg::fom_pin_t	pin_six,
	// margin pins and resolved fault levels
	output logic			raise_n,
	output logic			lower_n,
	output logic			lvl_five,
	output logic			lvl_six
);
	import fom_pkg::*;
	// margin pins follow the request
	assign {raise_n, lower_n} = drive_n;
	// an undriven pin rests at the pull-up level
	assign lvl_five = pin_five.oe ? pin_five.o : 1'b1;
	assign lvl_six = pin_six.oe ? pin_six.o : 1'b1;
endmodule

// ==== tb.sv ====
// ****************
// bench
// ****************
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fom_pkg::*;
	// registers, flags, expected a, b, any
	typedef struct packed {
		logic [7:0]	sa, ta, sb, tq;
		logic [11:0]	ov, uv, ew;
		logic [2:0]	ex;
	} fom_row_t;
	localparam fom_row_t ROWS [6] = '{
		'{8'h01, 8'h10, 8'h00, 8'h00, 12'h001, 12'h000, 12'h000, 3'h5},
		'{8'h01, 8'h20, 8'h02, 8'h90, 12'h003, 12'h000, 12'h000, 3'h3},
		'{8'h80, 8'h40, 8'h00, 8'hC8, 12'h000, 12'h000, 12'h880, 3'h7},
		'{8'h00, 8'h31, 8'hFF, 8'h1F, 12'h000, 12'h100, 12'h000, 3'h5},
		'{8'hFF, 8'h7F, 8'hFF, 8'hFF, 12'h000, 12'h000, 12'h000, 3'h0},
		'{8'hF0, 8'h10, 8'h0F, 8'h70, 12'h00F, 12'h000, 12'h000, 3'h3}
	};
	logic			clk, nrst, reg_wr, margin_in_n, margin_reg_en, cl;
	logic			seq_active, seq_fault, general_pin_two, general_pin_three;
	logic			fault_out_a, fault_out_b, any_fault, sequencing_fault_out;
	logic			margin_active, log_trigger, enables_off, trim_dac_out_close;
	logic			lvl_five, lvl_six;
	logic [7:0]		reg_addr, reg_wdata, reg_rdata;
	logic [1:0]		drive_n;
	logic [2:0]		pin_mode [6];
	logic [11:0]		dac_switch_cfg, trim_dac_out_sw;
	fom_flags_t [11:0]	monitored_input;
	fom_pin_t		general_pin_five, general_pin_six, general_pin_one, general_pin_four;
	fom_pin_t		any_fault_pin_two, any_fault_pin_three;
	fom_bank_t		trim_dac_bank, bk;
	int			errors, checks, cyc, n;
	// design and controller
	fom_top u_fom_top (
		.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .monitored_input,
		.pin_mode, .margin_in_n, .margin_reg_en, .seq_active, .seq_fault,
		.general_pin_two, .general_pin_three, .general_pin_one, .general_pin_four,
		.general_pin_five, .general_pin_six, .any_fault_pin_two, .any_fault_pin_three,
		.fault_out_a, .fault_out_b, .any_fault, .sequencing_fault_out, .margin_active,
		.log_trigger, .enables_off, .trim_dac_bank, .trim_dac_out_close, .dac_switch_cfg,
		.trim_dac_out_sw
	);
	fom_ctrl_model u_fom_ctrl_model (
		.drive_n, .pin_five(general_pin_five), .pin_six(general_pin_six),
		.raise_n(general_pin_two), .lower_n(general_pin_three), .lvl_five, .lvl_six
	);
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			errors++;
			test_done();
		end
	end
	// compares, bus cycles and helpers
	task automatic chk_bit(logic g, e, string m);
		chk_vec(16'(g), 16'(e), m);
	endtask
	task automatic chk_vec(logic [15:0] g, e, string m);
		checks++;
		if (g !== e) begin
			errors++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic step(int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic wr(logic [7:0] a, d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(logic [7:0] a, d);
		reg_addr = a;
		step(1);
		chk_vec(16'(reg_rdata), 16'(d), "rdata");
	endtask
	task automatic set_flags(logic [11:0] o, u, e);
		for (int j = 0; j < 12; j++)
			monitored_input[j] = {o[j], u[j], e[j]};
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// main sequence
	initial begin
		{nrst, reg_wr, seq_active, seq_fault, margin_reg_en, reg_addr, reg_wdata} = '0;
		margin_in_n = 1'b1;
		drive_n = 2'b11;
		dac_switch_cfg = 12'hA5C;
		pin_mode = '{3'h3, 3'h7, 3'h7, 3'h4, 3'h3, 3'h4};
		set_flags(12'h000, 12'h000, 12'h000);
		step(2);
		nrst = 1'b1;
		chk_bit(fault_out_a, 1'b0, "reset a");
		rd(8'h15, 8'h00);
		wr(8'h40, 8'hFF);
		rd(8'h40, 8'h00);
		$display("test reset done");
		foreach (ROWS[i]) begin
			wr(8'h15, ROWS[i].sa);
			wr(8'h16, ROWS[i].ta);
			wr(8'h17, ROWS[i].sb);
			wr(8'h18, ROWS[i].tq);
			rd(8'h16, ROWS[i].ta);
			set_flags(ROWS[i].ov, ROWS[i].uv, ROWS[i].ew);
			step(2);
			chk_bit(fault_out_a, ROWS[i].ex[2], "a");
			chk_bit(fault_out_b, ROWS[i].ex[1], "b");
			chk_bit(any_fault, ROWS[i].ex[0], "any");
			chk_bit(lvl_five, ROWS[i].ex[2] ^ !ROWS[i].ta[7], "pin5");
			chk_bit(lvl_six, ROWS[i].ex[1] ^ !ROWS[i].tq[7], "pin6");
			chk_vec(16'(general_pin_one), {14'h0, !ROWS[i].ex[0], 1'b1}, "pin1");
			chk_vec(16'(general_pin_four), {15'h0, ROWS[i].ex[0]}, "pin4");
		end
		$display("test table done");
		for (int k = 0; k < 4; k++) begin
			drive_n = 2'(k);
			step(5);
			cl = k == 1 || k == 2;
			bk = fom_bank_t'(k == 1 ? FOM_BANK_RAISE : k == 2 ? FOM_BANK_LOWER : FOM_BANK_NORMAL);
			chk_bit(any_fault_pin_two.oe | any_fault_pin_three.oe, 1'b0, "pin23");
			chk_vec(16'(trim_dac_bank), 16'(bk), "bank");
			chk_bit(trim_dac_out_close, cl, "close");
			chk_vec(16'(trim_dac_out_sw), cl ? 16'hFFF : 16'hA5C, "sw");
			if (k != 0)
				chk_bit(margin_active, cl, "margin");
		end
		$display("test margin done");
		drive_n = 2'b01;
		step(5);
		set_flags(12'h000, 12'h000, 12'h000);
		step(3);
		chk_bit(fault_out_b, 1'b1, "held b");
		chk_bit(any_fault, 1'b1, "held any");
		drive_n = 2'b11;
		step(5);
		chk_bit(fault_out_b, 1'b0, "free b");
		$display("test freeze done");
		pin_mode[5] = 3'h7;
		seq_active = 1'b1;
		seq_fault = 1'b1;
		n = 0;
		while (log_trigger !== 1'b1 && n < 10) begin
			step(1);
			n++;
		end
		chk_bit(log_trigger, 1'b1, "log");
		chk_bit(sequencing_fault_out, 1'b1, "seq");
		chk_bit(enables_off, 1'b1, "enables");
		chk_bit(lvl_six, 1'b0, "seq pin");
		step(1);
		chk_bit(log_trigger, 1'b0, "log once");
		$display("test sequencing done");
		margin_reg_en = 1'b1;
		step(1);
		chk_bit(sequencing_fault_out, 1'b0, "seq masked");
		chk_bit(margin_active, 1'b1, "reg margin");
		margin_reg_en = 1'b0;
		pin_mode[5] = 3'h0;
		margin_in_n = 1'b0;
		step(4);
		chk_bit(margin_active, 1'b1, "pin margin");
		margin_in_n = 1'b1;
		pin_mode[5] = 3'h7;
		$display("test margin enable done");
		nrst = 1'b0;
		step(1);
		chk_bit(sequencing_fault_out, 1'b0, "reset seq");
		nrst = 1'b1;
		rd(8'h16, 8'h00);
		chk_bit(log_trigger, 1'b1, "log after reset");
		$display("test reset again done");
		test_done();
	end
endmodule

bind fom_top fom_top_props #(.N_MON(N_MON), .N_DAC(N_DAC)) u_fom_top_props (
	.clk, .nrst, .monitored_input, .pin_mode, .general_pin_two, .general_pin_three,
	.fault_out_a, .fault_out_b, .any_fault, .sequencing_fault_out, .margin_active,
	.log_trigger, .enables_off, .trim_dac_bank, .trim_dac_out_close, .trim_dac_out_sw
);
